// File: logic/lpw_defines.svh
// Offsets, field positions, reset values and counts of the wake guard
`ifndef LPW_DEFINES_SVH
`define LPW_DEFINES_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define LPW_ADDR_CTRL    8'h00
`define LPW_ADDR_MODE    8'h04
`define LPW_ADDR_STATUS  8'h08
`define LPW_ADDR_TIMER   8'h0C
`define LPW_ADDR_BUSREG  8'h10
`define LPW_ADDR_VECTOR  8'h14

// ****************************************
// Field positions
// ****************************************
`define LPW_CTRL_OSCRUN  0
`define LPW_CTRL_SHORT_RECOVERY_SELECT   1
`define LPW_CTRL_PWRDIS  2
`define LPW_CTRL_RSTDIS  3
`define LPW_CTRL_STOPEN  4
`define LPW_CTRL_TRIP    5
`define LPW_CTRL_KPOL    8
`define LPW_ST_FLAG      0
`define LPW_ST_MONRST    1
`define LPW_ST_RECBUSY   2
`define LPW_ST_CORRUPT   3
`define LPW_ST_TPEND     4
`define LPW_TMR_EN       0
`define LPW_TMR_CNT      8
`define LPW_CMD_WAIT     2'h1
`define LPW_CMD_STOP     2'h2

// ****************************************
// Pin inputs, reset values, counts
// ****************************************
`define LPW_NPIN         13
`define LPW_P_RST        0
`define LPW_P_IRQ        1
`define LPW_P_BUS        2
`define LPW_P_BLW        3
`define LPW_P_ABV        4
`define LPW_P_KEY        5
`define LPW_PIN_IDLE     13'h1FE7
`define LPW_REC_LONG     4096
`define LPW_REC_SHORT    32
`define LPW_OSC_DIV      4
`define LPW_NSRC         26
`define LPW_STOP_MASK    26'h0068007

// ****************************************
// Vectors, highest priority first
// ****************************************
`define LPW_VECTORS '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF8, \
	16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEE, 16'hFFEC, \
	16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE0, \
	16'hFFDE, 16'hFFDC, 16'hFFDA, 16'hFFD8, 16'hFFD6, 16'hFFD4, \
	16'hFFD2, 16'hFFD0, 16'hFFCE, 16'hFFCC}

`endif

// File: logic/lpw_pkg.sv
// Types shared by the wake guard modules
package lpw_pkg;

	// Power modes, Gray along run, stop, recover
	typedef enum logic [1:0] {
		LPW_RUN  = 2'b00,
		LPW_STOP = 2'b01,
		LPW_REC  = 2'b11,
		LPW_WAIT = 2'b10
	} lpw_mode_t;

endpackage

// File: logic/lpw_rec_if.sv
// Handshake between the mode control and the stop recovery counter
`timescale 1ns/1ps
interface lpw_rec_if;
	logic start;
	logic short_sel;
	logic tick;
	logic busy;
	logic done;

	modport ctl (output start, short_sel, tick, input busy, done);
	modport rec (input start, short_sel, tick, output busy, done);
endinterface

// File: logic/lpw_recovery.sv
// Stop recovery counter clocked by oscillator ticks
`timescale 1ns/1ps
`include "lpw_defines.svh"
module lpw_recovery import lpw_pkg::*; #(
	parameter int CNT_W = 12,
	parameter int LONG  = `LPW_REC_LONG,
	parameter int SHORT = `LPW_REC_SHORT
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Control side
	lpw_rec_if.rec   rif
);

	// Counter must hold the longest delay
	if (LONG > (2 ** CNT_W) || SHORT < 1 || SHORT > LONG) begin : g_chk
		$error("lpw_recovery: delay does not fit counter");
	end

	localparam logic [CNT_W-1:0] LAST_L = CNT_W'(LONG - 1);
	localparam logic [CNT_W-1:0] LAST_S = CNT_W'(SHORT - 1);

	typedef struct packed {
		logic             busy;
		logic             done;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] last;
	} lpw_rec_st_t;

	lpw_rec_st_t q;
	lpw_rec_st_t d;

	// Length picked at start so a late write cannot stretch a delay
	always_comb begin
		d = q;
		d.done = 1'b0;
		if (rif.start) begin
			d.busy = 1'b1;
			d.cnt  = '0;
			d.last = rif.short_sel ? LAST_S : LAST_L;
		end else if (q.busy && rif.tick) begin
			if (q.cnt == q.last) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end else begin
				d.cnt = q.cnt + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rif.busy = q.busy;
	assign rif.done = q.done;

endmodule

// File: logic/lpw_vector_sel.sv
// Priority pick of the vector address among pending wake sources
`timescale 1ns/1ps
`include "lpw_defines.svh"
module lpw_vector_sel import lpw_pkg::*; #(
	parameter int NSRC = `LPW_NSRC
) (
	// Requests, index 0 highest priority
	input  wire logic [NSRC-1:0] req,
	// Selection
	output logic                 hit,
	output logic [15:0]          vec
);

	localparam logic [15:0] VEC_TBL [NSRC] = `LPW_VECTORS;

	// Scan from lowest priority up so the highest one wins last
	always_comb begin
		hit = |req;
		vec = VEC_TBL[0];
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				vec = VEC_TBL[i];
			end
		end
	end

endmodule

// File: logic/lpw_top.sv
// Low-power wake control, stop recovery and supply guard
// How it works
// - Wake timer runs in wait, register blocked
// - Timer runs in stop only with oscillator
// - Bus controller registers blocked during wait
// - Bus controller idle in stop, transfer corrupted
// - Wait exit restarts clock; resets give FFFE
// - Pin falling edge FFFA, emulation break FFFC
// - Clock generator FFF8, keyboard FFE0
// - First timer vectors FFF2, FFF4, FFF6
// - Second timer vectors FFF0 to FFEC, FFD2 to FFCC
// - Serial ports use FFEA to FFE2 vectors
// - Converter FFDE, wake timer FFDC
// - Bus controller vectors FFD4 to FFDA
// - Only listed events end stop mode
// - Key edge per polarity bit wakes stop
// - Timer rollover raises periodic wake request
// - Bus activity wakes; data ignored until sync
// - Recovery holds clocks 4096 oscillator cycles
// - Short recovery bit cuts delay to 32
// - Monitor enabled at reset; disable bits
// - Trip select 5 V set, 3 V reset
// - Monitor reset drives pin, holds until rise
// - Read-only flag with hysteresis, reset clears
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "lpw_defines.svh"
module lpw_top import lpw_pkg::*; #(
	parameter int OSC_DIV   = `LPW_OSC_DIV,
	parameter int REC_LONG  = `LPW_REC_LONG,
	parameter int REC_SHORT = `LPW_REC_SHORT,
	parameter int TMR_W     = 8
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Device pins
	input  wire logic        rst_pin_i,
	output logic             rst_pin_o,
	output logic             rst_pin_oe,
	input  wire logic        irq_pin_n,
	input  wire logic [7:0]  key_pin,
	input  wire logic        bus_rx_pin,
	// Supply comparator
	input  wire logic        below_fall_i,
	input  wire logic        above_rise_i,
	output logic             monitor_on_o,
	output logic             trip_level_o,
	// Event sources
	input  wire logic        emulation_mode,
	input  wire logic        break_req,
	input  wire logic        wdog_timeout,
	input  wire logic        clkgen_irq,
	input  wire logic [1:0]  first_timer_ch,
	input  wire logic        first_timer_ovf,
	input  wire logic [5:0]  second_timer_ch,
	input  wire logic        second_timer_ovf,
	input  wire logic [1:0]  sync_serial_irq,
	input  wire logic [2:0]  async_serial_irq,
	input  wire logic        adc_irq,
	input  wire logic [3:0]  bus_ctl_irq,
	input  wire logic        bus_xfer_active,
	input  wire logic        bit_sync_ok,
	// Clocks, reset and vector out
	output logic             cpu_clk_en,
	output logic             sys_clk_en,
	output logic             osc_run_o,
	output logic             bus_ctl_run,
	output logic             bus_rx_ignore,
	output logic             device_reset_o,
	output logic             vec_valid,
	output logic [15:0]      vec_addr
);

	localparam int NP   = `LPW_NPIN;
	localparam int NS   = `LPW_NSRC;
	localparam int DIVW = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
	localparam logic [DIVW-1:0] DIV_LAST = DIVW'(OSC_DIV - 1);
	localparam int REC_SHORT_MAX = REC_SHORT * OSC_DIV + 8;
	localparam logic [NS-1:0] STOP_MASK = `LPW_STOP_MASK;

	// Parameter limits
	if (OSC_DIV < 1 || TMR_W < 1 || TMR_W > 16) begin : g_chk
		$error("lpw_top: unsupported parameter value");
	end

	typedef struct packed {
		logic [NP-1:0]  s1;
		logic [NP-1:0]  s2;
		logic [NP-1:0]  s3;
		logic [NP-1:0]  pf;
		logic [NP-1:0]  pp;
		lpw_mode_t      mode;
		logic           osc_run;
		logic           short_recovery_select;
		logic           pwr_dis;
		logic           rst_dis;
		logic           stop_en;
		logic           trip;
		logic [7:0]     kpol;
		logic           tmr_en;
		logic [TMR_W-1:0] tcnt;
		logic           tpend;
		logic [31:0]    busreg;
		logic           corrupt;
		logic           ign;
		logic           flag;
		logic           lvi_rst;
		logic           rst_prev;
		logic [NS-1:0]  src;
		logic           vpend;
		logic           vvalid;
		logic [15:0]    vec;
		logic [31:0]    rdata;
		logic           err;
		logic [DIVW-1:0] div;
		logic           start;
	} lpw_top_st_t;

	lpw_top_st_t q;
	lpw_top_st_t d;

	lpw_rec_if rif ();

	// ****************************************
	// Pin events and request vectors
	// ****************************************
	logic [NP-1:0] fall;
	logic [NP-1:0] chg;
	logic [7:0]    kp;
	logic          irq_edge;
	logic          key_edge;
	logic          bus_act;
	logic          below;
	logic          above;
	logic          ext_rst;
	logic          rst_req;
	logic          osc_on;
	logic          tick;
	logic          mon_on;
	logic          tmr_act;
	logic [NS-1:0] req;
	logic [NS-1:0] stop_req;
	logic          sel_hit;
	logic [15:0]   sel_vec;

	assign fall     = q.pp & ~q.pf;
	assign chg      = q.pp ^ q.pf;
	assign kp       = q.pf[`LPW_P_KEY +: 8];
	assign irq_edge = fall[`LPW_P_IRQ];
	// New level equal to polarity bit is the wake edge
	assign key_edge = |(chg[`LPW_P_KEY +: 8] & ~(kp ^ q.kpol));
	assign bus_act  = fall[`LPW_P_BUS];
	assign below    = q.pf[`LPW_P_BLW];
	assign above    = q.pf[`LPW_P_ABV];
	// Own drive of the reset pin must not read back as external reset
	assign ext_rst  = ~q.pf[`LPW_P_RST] & ~q.lvi_rst;
	assign rst_req  = ext_rst | wdog_timeout | q.lvi_rst;
	assign osc_on   = (q.mode != LPW_STOP) | q.osc_run;
	assign tick     = osc_on && (q.div == DIV_LAST);
	assign mon_on   = ~q.pwr_dis & ((q.mode != LPW_STOP) | q.stop_en);
	assign tmr_act  = q.tmr_en & osc_on;

	// Index order follows vector priority
	assign req = {second_timer_ch[5:2],
		bus_ctl_irq[0], bus_ctl_irq[1], bus_ctl_irq[2],
		bus_ctl_irq[3] | ((q.mode == LPW_STOP) & bus_act),
		q.tpend, adc_irq, key_edge,
		async_serial_irq[0], async_serial_irq[1],
		async_serial_irq[2], sync_serial_irq[0], sync_serial_irq[1],
		second_timer_ovf, second_timer_ch[1], second_timer_ch[0],
		first_timer_ovf, first_timer_ch[1], first_timer_ch[0],
		clkgen_irq, irq_edge, break_req & emulation_mode, rst_req};

	// Watchdog has no clock in stop, so only pin and monitor resets
	assign stop_req = {req[NS-1:1] & STOP_MASK[NS-1:1],
		ext_rst | q.lvi_rst};

	lpw_vector_sel #(
		.NSRC (NS)
	) u_vsel (
		.req (q.src),
		.hit (sel_hit),
		.vec (sel_vec)
	);

	lpw_recovery #(
		.CNT_W (12),
		.LONG  (REC_LONG),
		.SHORT (REC_SHORT)
	) u_rec (
		.mclk  (mclk),
		.rst_n (rst_n),
		.rif   (rif)
	);

	assign rif.start     = q.start;
	assign rif.short_sel = q.short_recovery_select;
	assign rif.tick      = tick;

	// ****************************************
	// APB decode
	// ****************************************
	logic        setup;
	logic        acc_wr;
	logic        blocked;
	logic        mapped;
	logic [31:0] rd;

	assign setup  = psel & ~penable;
	assign acc_wr = psel & penable & pwrite & ~q.err;
	// Timer and bus controller cannot be reached outside run
	assign blocked = (q.mode != LPW_RUN) && ((paddr == `LPW_ADDR_TIMER)
		|| (paddr == `LPW_ADDR_BUSREG));

	// Read mux, captured in the setup cycle
	always_comb begin
		rd = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			`LPW_ADDR_CTRL: begin
				rd[`LPW_CTRL_OSCRUN] = q.osc_run;
				rd[`LPW_CTRL_SHORT_RECOVERY_SELECT]  = q.short_recovery_select;
				rd[`LPW_CTRL_PWRDIS] = q.pwr_dis;
				rd[`LPW_CTRL_RSTDIS] = q.rst_dis;
				rd[`LPW_CTRL_STOPEN] = q.stop_en;
				rd[`LPW_CTRL_TRIP]   = q.trip;
				rd[`LPW_CTRL_KPOL +: 8] = q.kpol;
			end
			`LPW_ADDR_MODE: rd[1:0] = q.mode;
			`LPW_ADDR_STATUS: begin
				rd[`LPW_ST_FLAG]    = q.flag;
				rd[`LPW_ST_MONRST]  = q.lvi_rst;
				rd[`LPW_ST_RECBUSY] = rif.busy;
				rd[`LPW_ST_CORRUPT] = q.corrupt;
				rd[`LPW_ST_TPEND]   = q.tpend;
			end
			`LPW_ADDR_TIMER: begin
				rd[`LPW_TMR_EN] = q.tmr_en;
				rd[`LPW_TMR_CNT +: TMR_W] = q.tcnt;
			end
			`LPW_ADDR_BUSREG: rd = q.busreg;
			`LPW_ADDR_VECTOR: rd[15:0] = q.vec;
			default: mapped = 1'b0;
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d = q;
		d.start  = 1'b0;
		d.vpend  = 1'b0;
		d.vvalid = q.vpend;
		// Three-stage pin sync, change taken when stages two and three agree
		d.s1 = {key_pin, above_rise_i, below_fall_i, bus_rx_pin,
			irq_pin_n, rst_pin_i};
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.pf = (q.s2 & q.s3) | (q.pf & (q.s2 | q.s3));
		d.pp = q.pf;
		d.rst_prev = rst_req;
		d.div = (!osc_on || q.div == DIV_LAST) ? '0 : q.div + 1'b1;
		if (q.vpend && sel_hit) begin
			d.vec = sel_vec;
		end
		// Apb setup: latch read data and the answer
		if (setup) begin
			d.rdata = (mapped && !blocked) ? rd : 32'h0000_0000;
			d.err   = !mapped || blocked;
		end
		// Wake timer counts oscillator ticks while active
		if (tick && tmr_act) begin
			d.tcnt = q.tcnt + 1'b1;
		end
		// Register writes at the access phase
		if (acc_wr) begin
			case (paddr)
				`LPW_ADDR_CTRL: begin
					d.osc_run = pwdata[`LPW_CTRL_OSCRUN];
					d.short_recovery_select   = pwdata[`LPW_CTRL_SHORT_RECOVERY_SELECT];
					d.pwr_dis = pwdata[`LPW_CTRL_PWRDIS];
					d.rst_dis = pwdata[`LPW_CTRL_RSTDIS];
					d.stop_en = pwdata[`LPW_CTRL_STOPEN];
					d.trip    = pwdata[`LPW_CTRL_TRIP];
					d.kpol    = pwdata[`LPW_CTRL_KPOL +: 8];
				end
				`LPW_ADDR_STATUS: begin
					if (pwdata[`LPW_ST_CORRUPT]) d.corrupt = 1'b0;
					if (pwdata[`LPW_ST_TPEND])   d.tpend   = 1'b0;
				end
				`LPW_ADDR_TIMER: begin
					d.tmr_en = pwdata[`LPW_TMR_EN];
				end
				`LPW_ADDR_BUSREG: d.busreg = pwdata;
				default: begin
				end
			endcase
		end
		// Sets after clears so a same-cycle event survives
		if (tick && tmr_act && (&q.tcnt)) begin
			d.tpend = 1'b1;
		end
		// Comparator hysteresis, held while the monitor is off
		if (mon_on && below) begin
			d.flag = 1'b1;
		end else if (mon_on && above) begin
			d.flag = 1'b0;
		end
		// Monitor reset holds until the rising threshold is passed
		if (mon_on && !q.rst_dis && below) begin
			d.lvi_rst = 1'b1;
		end else if (above) begin
			d.lvi_rst = 1'b0;
		end
		// Mode sequencing
		case (q.mode)
			LPW_RUN: begin
				if (rst_req && !q.rst_prev) begin
					d.src   = {{(NS-1){1'b0}}, 1'b1};
					d.vpend = 1'b1;
				end else if (acc_wr && paddr == `LPW_ADDR_MODE) begin
					if (pwdata[1:0] == `LPW_CMD_WAIT) begin
						d.mode = LPW_WAIT;
					end else if (pwdata[1:0] == `LPW_CMD_STOP) begin
						d.mode = LPW_STOP;
						d.ign  = 1'b1;
						if (bus_xfer_active) begin
							d.corrupt = 1'b1;
						end
					end
				end
			end
			LPW_WAIT: begin
				if (|req) begin
					d.mode  = LPW_RUN;
					d.src   = req;
					d.vpend = 1'b1;
				end
			end
			LPW_STOP: begin
				if (|stop_req) begin
					d.mode  = LPW_REC;
					d.src   = stop_req;
					d.start = 1'b1;
				end
			end
			LPW_REC: begin
				if (rif.done) begin
					d.mode  = LPW_RUN;
					d.vpend = 1'b1;
				end
			end
			default: d.mode = LPW_RUN;
		endcase
		// Bus data ignored until the link is back in step
		if (q.mode == LPW_RUN && bit_sync_ok) begin
			d.ign = 1'b0;
		end
	end

	// State register with synchronous reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			q      <= '0;
			q.s1   <= `LPW_PIN_IDLE;
			q.s2   <= `LPW_PIN_IDLE;
			q.s3   <= `LPW_PIN_IDLE;
			q.pf   <= `LPW_PIN_IDLE;
			q.pp   <= `LPW_PIN_IDLE;
			q.mode <= LPW_RUN;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata         = q.rdata;
	assign pready         = psel & penable;
	assign pslverr        = psel & penable & q.err;
	assign rst_pin_o      = 1'b0;
	assign rst_pin_oe     = q.lvi_rst;
	assign monitor_on_o   = mon_on;
	assign trip_level_o   = q.trip;
	assign cpu_clk_en     = (q.mode == LPW_RUN);
	assign sys_clk_en     = (q.mode == LPW_RUN) | (q.mode == LPW_WAIT);
	assign osc_run_o      = osc_on;
	assign bus_ctl_run    = sys_clk_en;
	assign bus_rx_ignore  = q.ign | ~sys_clk_en;
	assign device_reset_o = rst_req;
	assign vec_valid      = q.vvalid;
	assign vec_addr       = q.vec;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_rec_go;
		rif.start ##1 rif.busy;
	endsequence

	a_timer_wait_block: assert property (psel && penable && q.err
		|-> prdata == 32'h0000_0000)
		else $error("blocked access returned data");
	a_timer_stop_idle: assert property ((q.mode == LPW_STOP) && !q.osc_run
		|=> $stable(q.tcnt))
		else $error("wake timer moved in stop");
	a_bus_wait_block: assert property (setup && (q.mode == LPW_WAIT)
		&& (paddr == `LPW_ADDR_BUSREG) |=> pslverr)
		else $error("bus register reachable in wait");
	a_bus_stop_corrupt: assert property ((q.mode == LPW_RUN)
		&& (d.mode == LPW_STOP) && bus_xfer_active
		|=> q.corrupt && !bus_ctl_run)
		else $error("stop during transfer not flagged");
	a_wait_exit_clk: assert property ((q.mode == LPW_WAIT) && (|req)
		|=> cpu_clk_en ##1 vec_valid)
		else $error("wait exit did not restart clock");
	a_vec_reset_prio: assert property (q.vpend && q.src[0]
		|=> vec_valid && vec_addr == 16'hFFFE)
		else $error("reset vector not chosen");
	a_stop_wake_only: assert property ((q.mode == LPW_STOP) && !(|stop_req)
		|=> q.mode == LPW_STOP)
		else $error("stop left without wake event");
	a_rec_long_hold: assert property (s_rec_go and !rif.short_sel
		|-> ##1 (!sys_clk_en)[*7])
		else $error("clocks released early");
	a_rec_short_end: assert property (rif.start && rif.short_sel
		|-> ##[1:REC_SHORT_MAX] rif.done)
		else $error("short recovery too long");
	a_flag_hyst: assert property (mon_on && below |=> q.flag)
		else $error("supply flag not set");
	a_mon_pin_hold: assert property ($rose(q.lvi_rst) |-> rst_pin_oe
		&& device_reset_o until_with above)
		else $error("monitor reset not driven");
	a_timer_roll: assert property (tick && tmr_act && (&q.tcnt)
		|=> q.tpend)
		else $error("rollover lost");

endmodule

// File: logic/lpw_stop_mask_note.sv
// (unused)

// File: test/lpw_core_model.sv
// Core and peripheral request sources facing the wake guard
`timescale 1ns/1ps
module lpw_core_model (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// Bench commands
	input wire logic        go,
	input wire logic [25:0] raise,
	// Vector fetch
	input wire logic        vec_valid,
	// Level requests, index 0 highest
	output logic [25:0]     req
);
	// Sources hold a request until the core fetches a vector; a missed
	// stop-mode request is dropped with it, as the core would after reset
	always_ff @(posedge mclk) begin
		if (!rst_n || vec_valid) begin
			req <= 26'h0;
		end else if (go) begin
			req <= req | raise;
		end
	end
endmodule

// File: test/testbench.sv
// Self-checking bench of the wake guard
`timescale 1ns/1ps
`include "lpw_defines.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
	logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
	logic irq_pin_n = 1, bus_rx_pin = 1, bit_sync_ok = 0, bus_xfer_active = 0;
	logic below_fall_i = 0, above_rise_i = 0;
	logic [7:0] paddr = 8'h00, key_pin = 8'hFF;
	logic [31:0] pwdata = 32'h0, prdata, rdat, bdat;
	logic [25:0] raise = 26'h0, req;
	logic [15:0] vec_addr;
	logic pready, pslverr, rerr, rst_pin_oe, monitor_on_o, trip_level_o;
	logic cpu_clk_en, sys_clk_en, bus_ctl_run, bus_rx_ignore;
	logic device_reset_o, vec_valid;
	logic rst_pin_i = 1, osc_run_o, rst_pin_o;
	int err_total = 0, cmp_count = 0, a, b;
	// ****************************************
	// Design, partner and clock
	// ****************************************
	lpw_top #(.OSC_DIV(2), .REC_LONG(64), .REC_SHORT(32)) u_lpw_top (
		.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rst_pin_i(rst_pin_i),
		.rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
		.irq_pin_n(irq_pin_n),
		.key_pin(key_pin), .bus_rx_pin(bus_rx_pin),
		.below_fall_i(below_fall_i), .above_rise_i(above_rise_i),
		.monitor_on_o(monitor_on_o), .trip_level_o(trip_level_o),
		.emulation_mode(1'b1), .break_req(req[1]), .wdog_timeout(req[0]),
		.clkgen_irq(req[3]), .first_timer_ch(req[5:4]),
		.first_timer_ovf(req[6]), .second_timer_ch({req[25:22], req[8:7]}),
		.second_timer_ovf(req[9]), .sync_serial_irq({req[10], req[11]}),
		.async_serial_irq({req[12], req[13], req[14]}), .adc_irq(req[16]),
		.bus_ctl_irq({req[18], req[19], req[20], req[21]}),
		.bus_xfer_active(bus_xfer_active), .bit_sync_ok(bit_sync_ok),
		.cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
		.osc_run_o(osc_run_o),
		.bus_ctl_run(bus_ctl_run), .bus_rx_ignore(bus_rx_ignore),
		.device_reset_o(device_reset_o), .vec_valid(vec_valid),
		.vec_addr(vec_addr));
	lpw_core_model u_lpw_core_model (.mclk(mclk), .rst_n(rst_n), .go(go),
		.raise(raise), .vec_valid(vec_valid), .req(req));
	always #12.5 mclk = ~mclk;
	// ****************************************
	// Tasks and expectations
	// ****************************************
	// Vector pairs step down by two, second timer high channels apart
	function automatic logic [15:0] exp_vec(input int i);
		if (i < 22) return 16'hFFFE - 16'(2 * i);
		return 16'hFFD2 - 16'(2 * (i - 22));
	endfunction
	// Request held until pready seen at an edge
	task automatic apb(input logic wr, input logic [7:0] ad,
		input logic [31:0] wd);
		psel <= 1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge mclk);
	endtask
	task automatic wait_vec(input logic [15:0] ev);
		int n;
		n = 0;
		while (vec_valid !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		`CHK({vec_valid, vec_addr}, {1'b1, ev})
	endtask
	task automatic wake_wait(input logic [25:0] m, input logic [15:0] ev);
		apb(1, `LPW_ADDR_MODE, 32'h1);
		`CHK({cpu_clk_en, sys_clk_en}, 2'b01)
		if (m[1]) begin
			apb(0, `LPW_ADDR_TIMER, 32'h0);
			`CHK(rerr, 1'b1)
			apb(0, `LPW_ADDR_BUSREG, 32'h0);
			`CHK(rerr, 1'b1)
		end
		go <= 1;
		raise <= m;
		@(posedge mclk);
		go <= 0;
		wait_vec(ev);
	endtask
	// Stop entry, then a converter request raised in stop, then one wake event
	task automatic stop_wake(input logic [31:0] c, input int act,
		input logic [15:0] ev, input int rec);
		int n;
		n = 0;
		apb(1, `LPW_ADDR_CTRL, c);
		key_pin[0] <= (act != 1);
		apb(1, `LPW_ADDR_TIMER, 32'(act == 2));
		bus_xfer_active <= (act == 3);
		apb(1, `LPW_ADDR_STATUS, 32'h18);
		apb(1, `LPW_ADDR_MODE, 32'h2);
		go <= 1;
		raise <= 26'h10000;
		repeat (20) @(posedge mclk);
		go <= 0;
		`CHK({cpu_clk_en, sys_clk_en, bus_ctl_run}, 3'b000)
		`CHK(monitor_on_o, c[4])
		`CHK(osc_run_o, c[0])
		case (act)
			0: irq_pin_n <= 0;
			1: key_pin[0] <= 1;
			3: bus_rx_pin <= 0;
			default: ;
		endcase
		while (cpu_clk_en !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		if (rec > 0) `CHK(n inside {[rec * 2:rec * 2 + 12]}, 1'b1)
		wait_vec(ev);
		if (act == 3) begin
			`CHK(bus_rx_ignore, 1'b1)
			bit_sync_ok <= 1;
			apb(0, `LPW_ADDR_STATUS, 32'h0);
			`CHK({bus_rx_ignore, rdat[3]}, 2'b01)
			apb(0, `LPW_ADDR_BUSREG, 32'h0);
			`CHK(rdat, bdat)
		end
		irq_pin_n <= 1;
		bus_rx_pin <= 1;
		bus_xfer_active <= 0;
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ****************************************
	// Sequence and watchdog
	// ****************************************
	initial begin
		#(25 * 40000);
		err_total++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'hF2E418AD));
		repeat (5) @(posedge mclk);
		rst_n <= 1;
		@(posedge mclk);
		`CHK({monitor_on_o, trip_level_o, rst_pin_oe}, 3'b100)
		apb(0, 8'h3C, 32'h0);
		`CHK({rerr, rdat}, 33'h100000000)
		// Supply falls: reset vector, pin driven, flag kept in band
		below_fall_i <= 1;
		wait_vec(16'hFFFE);
		apb(0, `LPW_ADDR_STATUS, 32'h0);
		`CHK({rst_pin_o, rst_pin_oe, device_reset_o, rdat[1:0]}, 5'h0F)
		below_fall_i <= 0;
		apb(0, `LPW_ADDR_STATUS, 32'h0);
		`CHK({rst_pin_oe, rdat[0]}, 2'b11)
		above_rise_i <= 1;
		apb(1, `LPW_ADDR_STATUS, 32'h1);
		// Rising level needs the pin sync and one edge to clear the flag
		repeat (3) @(posedge mclk);
		apb(0, `LPW_ADDR_STATUS, 32'h0);
		`CHK({rst_pin_oe, device_reset_o, rdat[0]}, 3'b000)
		above_rise_i <= 0;
		apb(1, `LPW_ADDR_CTRL, 32'h2C);
		below_fall_i <= 1;
		apb(0, `LPW_ADDR_STATUS, 32'h0);
		`CHK({monitor_on_o, trip_level_o, rst_pin_oe}, 3'b010)
		below_fall_i <= 0;
		rst_n <= 0;
		repeat (5) @(posedge mclk);
		rst_n <= 1;
		@(posedge mclk);
		`CHK({monitor_on_o, trip_level_o}, 2'b10)
		// External reset pin low gives the reset vector
		rst_pin_i <= 0;
		wait_vec(16'hFFFE);
		`CHK(device_reset_o, 1'b1)
		rst_pin_i <= 1;
		repeat (5) @(posedge mclk);
		// Core-model sources 1 to 25 alone except 2, 15 and 17, watchdog with clock generator, then random pairs
		for (int i = 1; i < 26; i++)
			if (i != 2 && i != 15 && i != 17)
				wake_wait(26'h1 << i, exp_vec(i));
		wake_wait(26'h9, 16'hFFFE);
		repeat (20) begin
			a = $urandom_range(1, 25);
			b = $urandom_range(1, 25);
			if (a == 2 || a == 15 || a == 17) a++;
			if (b == 2 || b == 15 || b == 17) b++;
			wake_wait((26'h1 << a) | (26'h1 << b),
				exp_vec(a < b ? a : b));
		end
		apb(0, `LPW_ADDR_MODE, 32'h0);
		`CHK(rdat[1:0], 2'b00)
		// Stop exits; short delay only with oscillator kept running
		bdat = $urandom();
		apb(1, `LPW_ADDR_BUSREG, bdat);
		stop_wake(32'h0, 0, 16'hFFFA, 64);
		stop_wake(32'h113, 1, 16'hFFE0, 32);
		stop_wake(32'h1, 2, 16'hFFDC, 0);
		stop_wake(32'h10, 3, 16'hFFDA, 64);
		tally_and_finish();
	end
endmodule
